/* bench/psc_host_model.sv */
// Host-side model: serial master that frames one word per select cycle.
// Assumes the bench passes the SO wire in as seen, tri-state included.
`timescale 1ns/1ps
module psc_host_model (
	input wire logic clk_sys_in,
	input wire logic so_in,
	output logic cs_n_out,
	output logic sclk_out,
	output logic si_out
);
	// ----------------------------------------------------------------
	// Frame driver
	// ----------------------------------------------------------------
	// Idle with select high and clock low
	initial begin
		cs_n_out = 1'b1;
		sclk_out = 1'b0;
		si_out = 1'b1;
	end

	// Clock stays low at both select edges; any pulse count is driven as given
	task automatic xfer(input logic [15:0] word, input int pulses, output logic [7:0] rd);
		logic [15:0] sh;
		sh = word;
		rd = 8'h00;
		@(posedge clk_sys_in) cs_n_out <= 1'b0;
		repeat (2) @(posedge clk_sys_in);
		for (int n = 1; n <= pulses; n++) begin
			sclk_out <= 1'b1;
			// Three cycles high so SO has settled before it is taken
			repeat (3) @(posedge clk_sys_in);
			if (n > 8 && n <= 16) rd = {rd[6:0], so_in};
			sclk_out <= 1'b0;
			si_out <= sh[15];
			sh = {sh[14:0], ~sh[0]};
			repeat (2) @(posedge clk_sys_in);
		end
		cs_n_out <= 1'b1;
		// Data line is not held once the frame is over
		si_out <= ~si_out;
		repeat (3) @(posedge clk_sys_in);
	endtask
endmodule

/* bench/tb_top.sv */
// Self-checking bench for the power stage control select block.
// Assumes the host model frames all serial traffic.
`timescale 1ns/1ps
module tb_top;
	import psc_pkg::*;
	logic clk_sys_in, arst_n_in, pol, so, so_oe, cs_n, sclk, si;
	logic [5:0] din, pso, sel_m, ser_m;
	logic [7:0] rd;
	wire so_wire;
	int err_count, total_checks;

	// SO floats while the device does not drive it
	assign so_wire = so_oe ? so : 1'bz;

	psc_top psc_top_i (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .cs_n_in(cs_n),
		.sclk_in(sclk), .si_in(si), .so_out(so), .so_oe_out(so_oe),
		.input_polarity_pin_in(pol), .channel_direct_input_in(din),
		.power_stage_output_out(pso));
	psc_host_model psc_host_model_i (.clk_sys_in(clk_sys_in), .so_in(so_wire),
		.cs_n_out(cs_n), .sclk_out(sclk), .si_out(si));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	initial begin
		clk_sys_in = 1'b0;
		forever #25 clk_sys_in = ~clk_sys_in;
	end

	task automatic end_sim();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [5:0] cmd, input logic [7:0] data, input int pulses);
		logic [7:0] dummy;
		psc_host_model_i.xfer({cmd, 2'b00, data}, pulses, dummy);
	endtask

	task automatic rdreg(input logic [5:0] cmd);
		psc_host_model_i.xfer({cmd, 2'b00, 8'h00}, 16, rd);
	endtask

	// Sweep polarity and direct inputs against the truth table
	task automatic sweep();
		logic [5:0] pats [4] = '{6'h00, 6'h3f, 6'h15, 6'h2a};
		logic [5:0] e;
		for (int p = 0; p < 2; p++) begin
			foreach (pats[i]) begin
				@(posedge clk_sys_in);
				din <= pats[i];
				pol <= p[0];
				repeat (2) @(posedge clk_sys_in);
				#1;
				// Truth table per channel, kept apart from the design's vector form
				for (int c = 0; c < 6; c++) begin
					if (sel_m[c]) begin
						e[c] = (pats[i][c] == p[0]);
					end else begin
						e[c] = !ser_m[c];
					end
				end
				chk({2'b00, pso}, {2'b00, e});
			end
		end
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic sc_reset_values();
		rdreg(READ_PARALLEL_SELECT_CMD);
		chk(rd, CTRL_RESET);
		rdreg(READ_SERIAL_STATE_CMD);
		chk(rd, CTRL_RESET);
		sweep();
	endtask

	// Mixed control: written low bits of 00 must read back as ones
	task automatic sc_mixed();
		wr(WRITE_SERIAL_STATE_CMD, 8'h5c, 16);
		wr(WRITE_PARALLEL_SELECT_CMD, 8'h90, 16);
		ser_m = 6'h17;
		sel_m = 6'h24;
		rdreg(READ_SERIAL_STATE_CMD);
		chk(rd, 8'h5f);
		rdreg(READ_PARALLEL_SELECT_CMD);
		chk(rd, 8'h93);
		sweep();
		wr(WRITE_SERIAL_STATE_CMD, 8'h00, 16);
		ser_m = 6'h00;
		sweep();
	endtask

	// Short, long and unknown frames leave the register alone
	task automatic sc_refused();
		wr(WRITE_PARALLEL_SELECT_CMD, 8'hfc, 15);
		wr(WRITE_PARALLEL_SELECT_CMD, 8'hfc, 17);
		wr(6'h2e, 8'hfc, 16);
		// Wrong address prefix: SO must stay released through the second byte
		psc_host_model_i.xfer({6'h1a, 2'b00, 8'hfc}, 16, rd);
		chk(rd, 8'hzz);
		rdreg(READ_PARALLEL_SELECT_CMD);
		chk(rd, 8'h93);
		sweep();
	endtask

	// Reset in mid-run forces stages off and restores both registers
	task automatic sc_reset_mid();
		@(posedge clk_sys_in);
		arst_n_in <= 1'b0;
		#1;
		chk({2'b00, pso}, 8'h00);
		repeat (3) @(posedge clk_sys_in);
		#1;
		chk({2'b00, pso}, 8'h00);
		@(posedge clk_sys_in);
		arst_n_in <= 1'b1;
		sel_m = 6'h3f;
		ser_m = 6'h3f;
		repeat (2) @(posedge clk_sys_in);
		rdreg(READ_PARALLEL_SELECT_CMD);
		chk(rd, CTRL_RESET);
		rdreg(READ_SERIAL_STATE_CMD);
		chk(rd, CTRL_RESET);
	endtask

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		pol = 1'b0;
		din = 6'h00;
		sel_m = 6'h3f;
		ser_m = 6'h3f;
		// Reset falls after time zero so no flop can miss the edge
		#1;
		arst_n_in = 1'b0;
		repeat (20) @(posedge clk_sys_in);
		arst_n_in <= 1'b1;
		repeat (2) @(posedge clk_sys_in);
		sc_reset_values();
		sc_mixed();
		sc_refused();
		sc_reset_mid();
		end_sim();
	end

	// More than ten times the expected run length
	initial begin
		#1000000;
		err_count++;
		end_sim();
	end
endmodule

/* hw/psc_frame_rx.sv */
// Serial frame receiver: shifts select-low frames and counts clock edges.
// Assumes chip select, serial clock and data are synchronous to clk_sys_in
// and the serial clock is far slower than the system clock.
`timescale 1ns/1ps
module psc_frame_rx (
	input wire logic clk_sys_in,
	input wire logic arst_n_in,
	input wire logic cs_n_in,
	input wire logic sclk_in,
	input wire logic si_in,
	psc_frame_if.rx frame
);
	import psc_pkg::*;

	logic sclk_prev_reg, sclk_prev_next;
	logic cs_n_prev_reg, cs_n_prev_next;
	logic [15:0] shift_reg, shift_next;
	logic [4:0] fall_cnt_reg, fall_cnt_next;
	logic [4:0] rise_cnt_reg, rise_cnt_next;
	logic sclk_fall, sclk_rise;

	// ----------------------------------------------------------------
	// Edge detection and frame boundaries
	// ----------------------------------------------------------------
	// Edges only count while select is low; anything else is ignored
	assign sclk_fall = sclk_prev_reg & ~sclk_in & ~cs_n_in;
	assign sclk_rise = ~sclk_prev_reg & sclk_in & ~cs_n_in;
	assign frame.active = ~cs_n_in;
	assign frame.fall_pulse = sclk_fall;
	assign frame.frame_done = ~cs_n_prev_reg & cs_n_in;
	assign frame.fall_cnt = fall_cnt_reg;
	assign frame.rise_cnt = rise_cnt_reg;
	assign frame.shift_word = shift_reg;

	// Next state: shift on falling edges, saturate the counters
	always_comb begin
		sclk_prev_next = sclk_in;
		cs_n_prev_next = cs_n_in;
		shift_next = shift_reg;
		fall_cnt_next = fall_cnt_reg;
		rise_cnt_next = rise_cnt_reg;
		if (cs_n_in) begin
			// Counters clear between frames, after frame_done was seen
			fall_cnt_next = '0;
			rise_cnt_next = '0;
		end else begin
			if (sclk_fall) begin
				shift_next = {shift_reg[14:0], si_in};
				// Saturation keeps long frames from wrapping back to 16
				if (fall_cnt_reg != CNT_MAX) begin
					fall_cnt_next = fall_cnt_reg + 5'h01;
				end
			end
			if (sclk_rise && rise_cnt_reg != CNT_MAX) begin
				rise_cnt_next = rise_cnt_reg + 5'h01;
			end
		end
	end

	// Registers; reset clears the shift register
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			sclk_prev_reg <= 1'b0;
			cs_n_prev_reg <= 1'b1;
			shift_reg <= '0;
			fall_cnt_reg <= '0;
			rise_cnt_reg <= '0;
		end else begin
			sclk_prev_reg <= sclk_prev_next;
			cs_n_prev_reg <= cs_n_prev_next;
			shift_reg <= shift_next;
			fall_cnt_reg <= fall_cnt_next;
			rise_cnt_reg <= rise_cnt_next;
		end
	end

endmodule

/* hw/psc_top.sv */
// Control selection for six low-side power stages behind a serial port.
// Assumes all pins are synchronous to clk_sys_in; arst_n_in is the reset pin.
// Operation
// - A one in a channel's parallel-select bit routes its direct input, a zero its serial bit.
// - Under serial control a zero serial-state bit turns the stage on and a one turns it off.
// - Under parallel control the stage is on when direct input equals the polarity pin.
// - Serial channels ignore direct input and polarity; parallel channels ignore serial bits.
// - Parallel-select bits for channels 6..1 sit in bits 7..2 and reset to all ones.
// - Serial-state bits for channels 6..1 sit in bits 7..2 and reset to all ones.
// - The two low bits of both registers always read back as ones.
// - Reset low forces every stage off and clears the serial shift register.
// - A write lands only when exactly sixteen serial clock pulses came in the frame.
`timescale 1ns/1ps
module psc_top
	import psc_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic arst_n_in,
	input wire logic cs_n_in,
	input wire logic sclk_in,
	input wire logic si_in,
	output logic so_out,
	output logic so_oe_out,
	input wire logic input_polarity_pin_in,
	input wire logic [psc_pkg::NUM_CH-1:0] channel_direct_input_in,
	output logic [psc_pkg::NUM_CH-1:0] power_stage_output_out
);
	import psc_pkg::*;

	psc_frame_if frame();

	logic [NUM_CH-1:0] parallel_select_reg, parallel_select_next;
	logic [NUM_CH-1:0] serial_state_reg, serial_state_next;
	logic [NUM_CH-1:0] stage_on_reg, stage_on_next;
	logic [5:0] cmd_reg, cmd_next;
	logic prefix_ok_reg, prefix_ok_next;
	logic so_reg, so_next;
	logic frame_ok;
	logic [5:0] frame_cmd;
	logic [NUM_CH-1:0] frame_data;
	logic [7:0] second_byte;
	logic [15:0] tx_word;
	logic [3:0] tx_idx;

	// Channel source selection for the output path; the checks work it out on their own
	function automatic logic [NUM_CH-1:0] stage_select(input logic [NUM_CH-1:0] sel,
		input logic [NUM_CH-1:0] ser, input logic [NUM_CH-1:0] din, input logic pol);
		logic [NUM_CH-1:0] par_on;
		par_on = din ~^ {NUM_CH{pol}};
		return (sel & par_on) | (~sel & ~ser);
	endfunction

	// ----------------------------------------------------------------
	// Frame receiver
	// ----------------------------------------------------------------
	psc_frame_rx u_rx (
		.clk_sys_in(clk_sys_in),
		.arst_n_in(arst_n_in),
		.cs_n_in(cs_n_in),
		.sclk_in(sclk_in),
		.si_in(si_in),
		.frame(frame.rx)
	);

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	// Frame fields as they stand when select rises
	assign frame_ok = frame.frame_done && frame.fall_cnt == FRAME_BITS;
	assign frame_cmd = frame.shift_word[15:10];
	assign frame_data = frame.shift_word[CH_MSB:CH_LSB];

	// Register updates; the low two data bits are dropped, not stored
	always_comb begin
		parallel_select_next = parallel_select_reg;
		serial_state_next = serial_state_reg;
		if (frame_ok && frame_cmd == WRITE_PARALLEL_SELECT_CMD) begin
			parallel_select_next = frame_data;
		end
		if (frame_ok && frame_cmd == WRITE_SERIAL_STATE_CMD) begin
			serial_state_next = frame_data;
		end
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			parallel_select_reg <= CTRL_RESET[CH_MSB:CH_LSB];
			serial_state_reg <= CTRL_RESET[CH_MSB:CH_LSB];
		end else begin
			parallel_select_reg <= parallel_select_next;
			serial_state_reg <= serial_state_next;
		end
	end

	// ----------------------------------------------------------------
	// Power stage drive
	// ----------------------------------------------------------------
	// Registered so reset can hold every stage off regardless of inputs
	always_comb begin
		stage_on_next = stage_select(parallel_select_reg, serial_state_reg,
			channel_direct_input_in, input_polarity_pin_in);
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			stage_on_reg <= '0;
		end else begin
			stage_on_reg <= stage_on_next;
		end
	end

	assign power_stage_output_out = stage_on_reg;

	// ----------------------------------------------------------------
	// Serial read-back
	// ----------------------------------------------------------------
	// Second byte chosen from the command once eight bits have arrived
	always_comb begin
		unique case (cmd_reg)
			READ_PARALLEL_SELECT_CMD: second_byte = {parallel_select_reg, UNUSED_READ};
			READ_SERIAL_STATE_CMD: second_byte = {serial_state_reg, UNUSED_READ};
			default: second_byte = DIAG_SECOND_IDLE;
		endcase
		tx_word = {FIRST_PAD, DIAG_FIRST_IDLE, second_byte};
		// Bit 15 stands from select low through the first rising edge; each later rising edge up to the sixteenth moves one bit on
		if (frame.rise_cnt == '0) begin
			tx_idx = FIRST_BIT;
		end else if (frame.rise_cnt > BIT_TOP) begin
			tx_idx = '0;
		end else begin
			tx_idx = 4'(BIT_TOP - frame.rise_cnt);
		end
		so_next = tx_word[tx_idx];
		cmd_next = cmd_reg;
		prefix_ok_next = prefix_ok_reg;
		if (!frame.active) begin
			cmd_next = '0;
			prefix_ok_next = 1'b0;
		end else begin
			if (frame.fall_cnt == PREFIX_BITS) begin
				prefix_ok_next = frame.shift_word[1:0] == ADDR_PREFIX;
			end
			if (frame.fall_cnt == CMD_BITS) begin
				cmd_next = frame.shift_word[7:2];
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cmd_reg <= '0;
			prefix_ok_reg <= 1'b0;
			so_reg <= 1'b1;
		end else begin
			cmd_reg <= cmd_next;
			prefix_ok_reg <= prefix_ok_next;
			so_reg <= so_next;
		end
	end

	// Other devices may share select, so drive only once addressed
	assign so_oe_out = frame.active && prefix_ok_reg && frame.fall_cnt >= PREFIX_BITS;
	assign so_out = so_reg;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!arst_n_in);

	sequence s_good_frame(logic [5:0] code);
		frame.frame_done && frame.fall_cnt == FRAME_BITS && frame_cmd == code;
	endsequence

	sequence s_bad_frame;
		frame.frame_done && frame.fall_cnt != FRAME_BITS;
	endsequence

	a_serial_stage_drive: assert property (1'b1 |=>
		((~$past(parallel_select_reg)) & (power_stage_output_out ^ ~$past(serial_state_reg))) == '0)
		else $error("serial channel output does not follow its serial bit");

	a_parallel_stage_drive: assert property (1'b1 |=>
		($past(parallel_select_reg) & (power_stage_output_out ^
		($past(channel_direct_input_in) ~^ {NUM_CH{$past(input_polarity_pin_in)}}))) == '0)
		else $error("parallel channel output does not follow its input");

	a_source_ignored: assert property ($stable(parallel_select_reg) &&
		$stable(serial_state_reg) ##1
		$stable(parallel_select_reg) && $stable(serial_state_reg)
		|=> ((~$past(parallel_select_reg)) &
		(power_stage_output_out ^ $past(power_stage_output_out))) == '0)
		else $error("serial channel moved without a serial bit change");

	a_reset_stage_off: assert property (disable iff (1'b0) !arst_n_in |->
		power_stage_output_out == '0 && u_rx.shift_reg == '0)
		else $error("stage on or shift register set during reset");

	a_reset_values: assert property (disable iff (1'b0) $rose(arst_n_in) |->
		parallel_select_reg == CTRL_RESET[CH_MSB:CH_LSB] &&
		serial_state_reg == CTRL_RESET[CH_MSB:CH_LSB])
		else $error("control registers not at reset value");

	a_select_write: assert property (s_good_frame(WRITE_PARALLEL_SELECT_CMD) |=>
		parallel_select_reg == $past(frame_data) && $stable(serial_state_reg))
		else $error("parallel-select write did not land");

	a_state_write: assert property (s_good_frame(WRITE_SERIAL_STATE_CMD) |=>
		serial_state_reg == $past(frame_data) && $stable(parallel_select_reg))
		else $error("serial-state write did not land");

	a_count_gate: assert property (s_bad_frame |=>
		$stable(parallel_select_reg) && $stable(serial_state_reg))
		else $error("register changed on a frame without sixteen pulses");

	a_low_bits_high: assert property (so_oe_out && frame.rise_cnt > 5'h0e &&
		frame.rise_cnt <= BIT_TOP && (cmd_reg == READ_PARALLEL_SELECT_CMD ||
		cmd_reg == READ_SERIAL_STATE_CMD) |-> ##1 so_out)
		else $error("unused register bits did not read as one");

endmodule

/* inc/psc_frame_if.sv */
// Carrier between the serial frame receiver and the control core.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface psc_frame_if;
	logic active;
	logic fall_pulse;
	logic frame_done;
	logic [4:0] fall_cnt;
	logic [4:0] rise_cnt;
	logic [15:0] shift_word;

	modport rx(output active, fall_pulse, frame_done, fall_cnt, rise_cnt, shift_word);
	modport core(input active, fall_pulse, frame_done, fall_cnt, rise_cnt, shift_word);
endinterface

/* inc/psc_pkg.sv */
// Constants shared by the power stage control select block.
// Assumes one 20 MHz system clock; serial pins arrive synchronous to it.
package psc_pkg;

	// ----------------------------------------------------------------
	// Channel and register layout
	// ----------------------------------------------------------------
	localparam int NUM_CH = 6;
	localparam int CH_LSB = 2;
	localparam int CH_MSB = 7;
	localparam logic [7:0] CTRL_RESET = 8'hff;
	localparam logic [1:0] UNUSED_READ = 2'h3;

	// ----------------------------------------------------------------
	// Serial frame layout
	// ----------------------------------------------------------------
	localparam int FRAME_W = 16;
	localparam int CNT_W = 5;
	localparam logic [4:0] CNT_MAX = 5'h1f;
	localparam logic [4:0] FRAME_BITS = 5'h10;
	localparam logic [4:0] PREFIX_BITS = 5'h02;
	localparam logic [4:0] CMD_BITS = 5'h08;
	localparam logic [3:0] FIRST_BIT = 4'hf;
	localparam logic [4:0] BIT_TOP = 5'h10;
	localparam logic [1:0] ADDR_PREFIX = 2'h2;
	localparam logic [1:0] FIRST_PAD = 2'h3;

	// Six-bit command codes, the two don't-care bits dropped
	localparam logic [5:0] WRITE_SERIAL_STATE_CMD = 6'h26;
	localparam logic [5:0] READ_SERIAL_STATE_CMD = 6'h25;
	localparam logic [5:0] WRITE_PARALLEL_SELECT_CMD = 6'h2a;
	localparam logic [5:0] READ_PARALLEL_SELECT_CMD = 6'h29;

	// Diagnostics live outside this block; report healthy stages
	localparam logic [5:0] DIAG_FIRST_IDLE = 6'h3f;
	localparam logic [7:0] DIAG_SECOND_IDLE = 8'hff;

endpackage
